// ==== core/lef_pkg.sv ====
// Constants for the link event flags and cycle timer block
package lef_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h10;
	localparam logic [7:0] ADDR_CYCLE_TIME = 8'h14;
	localparam logic [7:0] ADDR_FLAG_MASK = 8'h40;
	localparam logic [7:0] ADDR_HDR_CTRL = 8'h90;
	// Reset values
	localparam logic [31:0] CYCLE_TIME_RESET = 32'h0000_0000;
	localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic HDR_STRIP_RESET = 1'b0;
	// Documented positions count bit 0 as the word MSB
	localparam int WORD_MSB = 31;
	localparam int BIT_SUMMARY = WORD_MSB - 0;
	localparam int BIT_CYCLE_SECOND_FLAG = WORD_MSB - 13;
	localparam int BIT_HDR_READ = WORD_MSB - 16;
	localparam int BIT_FAIR_GAP = WORD_MSB - 17;
	localparam int BIT_TX_IDLE = WORD_MSB - 18;
	localparam int BIT_CY_DONE = WORD_MSB - 19;
	localparam int BIT_CY_PEND = WORD_MSB - 20;
	localparam int BIT_CY_LOST = WORD_MSB - 21;
	localparam int BIT_CY_ARBF = WORD_MSB - 22;
	localparam int BIT_ATX_END = WORD_MSB - 24;
	localparam int BIT_ARX_REQ = WORD_MSB - 25;
	localparam int BIT_MGMT_DONE = WORD_MSB - 26;
	localparam int BIT_CMD_DONE = WORD_MSB - 27;
	localparam int BIT_DTX_DONE = WORD_MSB - 28;
	localparam int BIT_DRX_DONE = WORD_MSB - 29;
	localparam int BIT_TX_EXPR = WORD_MSB - 30;
	localparam int BIT_AGENT_WR = WORD_MSB - 31;
	localparam int BIT_HDR_STRIP = WORD_MSB - 0;
	// Cycle timer fields
	localparam int SEC_LSB = WORD_MSB - 6;
	localparam int SEC_W = 7;
	localparam int CNT_LSB = WORD_MSB - 19;
	localparam int CNT_W = 13;
	localparam int OFF_LSB = WORD_MSB - 31;
	localparam int OFF_W = 12;
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int OFFSET_TICK_NS = 40;
	localparam int CYCLE_PERIOD_US = 125;
	localparam int CYCLE_PERIOD_NS = CYCLE_PERIOD_US * 1000;
	localparam int OFFSET_WRAP = CYCLE_PERIOD_NS / OFFSET_TICK_NS;
	localparam int CYCLES_PER_SECOND = 1000000 / CYCLE_PERIOD_US;
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== core/lef_event_flags_cycle_timer.sv ====
// Link event flag register, flag mask and isochronous cycle timer
// How it works
// - Host read of receive-DMA header sets flag 16, unless stripping set
// - Bus idle for an arbitration reset gap sets flag 17
// - Transmitter turning idle sets flag 18
// - Arbitration gap after a sent or received cycle start sets flag 19
// - Offset reaching zero sets flag 20; it holds until cycle end
// - Two offset rollovers without received cycle start set flag 21
// - Lost cycle-start arbitration sets flag 22
// - Async transmit completion sets flag 24; status kept elsewhere
// - Response to own request sets flag 24; plain request does not
// - Only a received request sets flag 25, never a response
// - Management ORB stored sets flag 26
// - Command ORB stored sets flag 27
// - All DMA transmit blocks completed sets flag 28
// - All DMA receive blocks completed sets flag 29
// - Transmitter delivery failure sets flag 30
// - Any agent register write sets flag 31
// - Cycle timer is zero after reset; bus reset leaves it
// - Seconds in bits 0-6, writable, step on cycle count rollover
// - Cycle count in bits 7-19, writable, step on offset rollover
// - Offset in bits 20-31, writable, steps every 40 ns
// - Seconds increment sets flag 13
// - Summary bit 0 is OR of masked flags; interrupt pin is inverse
`timescale 1ns/1ps
`default_nettype none
module lef_event_flags_cycle_timer #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic ev_rx_header_read,
	input wire logic ev_fair_gap,
	input wire logic tx_idle,
	input wire logic ev_arb_gap,
	input wire logic ev_cycle_start,
	input wire logic ev_cycle_start_rx,
	input wire logic ev_iso_cycle_end,
	input wire logic ev_cycle_arb_lost,
	input wire logic ev_async_tx_complete,
	input wire logic ev_async_rx_response,
	input wire logic ev_async_rx_request,
	input wire logic ev_mgmt_orb_stored,
	input wire logic ev_cmd_orb_stored,
	input wire logic ev_dma_tx_all_done,
	input wire logic ev_dma_rx_all_done,
	input wire logic ev_tx_failed,
	input wire logic ev_agent_write,
	output logic rx_header_strip_ctrl,
	output logic irq_out_n
);
	localparam int OFF_W = lef_pkg::OFF_W;
	localparam int CNT_W = lef_pkg::CNT_W;
	localparam int SEC_W = lef_pkg::SEC_W;

	// Bus slave state
	logic [ADDR_W-1:0] wr_addr, next_wr_addr;
	logic [31:0] wr_data, next_wr_data;
	logic [3:0] wr_strb, next_wr_strb;
	logic next_awready, next_wready, next_bvalid;
	logic [1:0] next_bresp;
	logic next_arready, next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic wr_go;
	logic [31:0] wr_mask;
	logic [7:0] wr_a8, rd_a8;

	// Block state
	logic [31:0] cycle_time, next_cycle_time;
	logic [31:0] flags, next_flags;
	logic [31:0] flag_mask, next_flag_mask;
	logic next_strip;
	logic [5:0] tick_acc, next_tick_acc;
	logic wrap_seen, next_wrap_seen;
	logic cs_seen, next_cs_seen;
	logic tx_idle_q, next_tx_idle_q;
	logic next_irq_n;

	// Counter helpers
	logic [6:0] acc_sum;
	logic [1:0] ticks;
	logic [OFF_W:0] off_sum;
	logic off_wrap, cnt_wrap, ct_wr;
	logic [CNT_W-1:0] cnt_now;
	logic [SEC_W-1:0] sec_now;
	logic [31:0] counted, flag_set, flag_clr;

	localparam logic [31:0] FLAGS_IMPL = (32'h1 << lef_pkg::BIT_CYCLE_SECOND_FLAG)
		| (32'h1 << lef_pkg::BIT_HDR_READ) | (32'h1 << lef_pkg::BIT_FAIR_GAP)
		| (32'h1 << lef_pkg::BIT_TX_IDLE) | (32'h1 << lef_pkg::BIT_CY_DONE)
		| (32'h1 << lef_pkg::BIT_CY_PEND) | (32'h1 << lef_pkg::BIT_CY_LOST)
		| (32'h1 << lef_pkg::BIT_CY_ARBF) | (32'h1 << lef_pkg::BIT_ATX_END)
		| (32'h1 << lef_pkg::BIT_ARX_REQ) | (32'h1 << lef_pkg::BIT_MGMT_DONE)
		| (32'h1 << lef_pkg::BIT_CMD_DONE) | (32'h1 << lef_pkg::BIT_DTX_DONE)
		| (32'h1 << lef_pkg::BIT_DRX_DONE) | (32'h1 << lef_pkg::BIT_TX_EXPR)
		| (32'h1 << lef_pkg::BIT_AGENT_WR);

	// Bus slave: address and data latched in either order, answer after both
	always_comb begin
		wr_a8 = 8'(wr_addr);
		rd_a8 = 8'(araddr);
		wr_go = !awready && !wready && !bvalid;
		wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}},
			{8{wr_strb[0]}}};
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		next_wr_strb = wr_strb;
		next_awready = awready;
		next_wready = wready;
		next_bvalid = bvalid;
		next_bresp = bresp;
		if (awvalid && awready) begin
			next_wr_addr = awaddr;
			next_awready = 1'b0;
		end
		if (wvalid && wready) begin
			next_wr_data = wdata;
			next_wr_strb = wstrb;
			next_wready = 1'b0;
		end
		if (wr_go) begin
			next_bvalid = 1'b1;
			unique case (wr_a8)
				lef_pkg::ADDR_EVENT_FLAGS, lef_pkg::ADDR_CYCLE_TIME,
				lef_pkg::ADDR_FLAG_MASK, lef_pkg::ADDR_HDR_CTRL:
					next_bresp = lef_pkg::RESP_OKAY;
				default: next_bresp = lef_pkg::RESP_SLVERR;
			endcase
		end
		if (bvalid && bready) begin
			next_bvalid = 1'b0;
			next_awready = 1'b1;
			next_wready = 1'b1;
		end
		next_arready = arready;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (arvalid && arready) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = lef_pkg::RESP_OKAY;
			unique case (rd_a8)
				lef_pkg::ADDR_EVENT_FLAGS: begin
					next_rdata = flags;
					next_rdata[lef_pkg::BIT_SUMMARY] = !irq_out_n;
				end
				lef_pkg::ADDR_CYCLE_TIME: next_rdata = cycle_time;
				lef_pkg::ADDR_FLAG_MASK: next_rdata = flag_mask;
				lef_pkg::ADDR_HDR_CTRL: begin
					next_rdata = 32'h0;
					next_rdata[lef_pkg::BIT_HDR_STRIP] = rx_header_strip_ctrl;
				end
				default: begin
					next_rdata = 32'h0;
					next_rresp = lef_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (rvalid && rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
	end

	// Cycle timer; 50 ns clock against 40 ns ticks, so one or two per edge
	always_comb begin
		acc_sum = {1'b0, tick_acc} + 7'(lef_pkg::CLK_PERIOD_NS);
		if (acc_sum >= 7'(2 * lef_pkg::OFFSET_TICK_NS)) begin
			ticks = 2'd2;
			next_tick_acc = 6'(acc_sum - 7'(2 * lef_pkg::OFFSET_TICK_NS));
		end else if (acc_sum >= 7'(lef_pkg::OFFSET_TICK_NS)) begin
			ticks = 2'd1;
			next_tick_acc = 6'(acc_sum - 7'(lef_pkg::OFFSET_TICK_NS));
		end else begin
			ticks = 2'd0;
			next_tick_acc = 6'(acc_sum);
		end
		cnt_now = cycle_time[lef_pkg::CNT_LSB +: CNT_W];
		sec_now = cycle_time[lef_pkg::SEC_LSB +: SEC_W];
		off_sum = {1'b0, cycle_time[lef_pkg::OFF_LSB +: OFF_W]}
			+ (OFF_W+1)'(ticks);
		off_wrap = off_sum >= (OFF_W+1)'(lef_pkg::OFFSET_WRAP);
		cnt_wrap = off_wrap
			&& cnt_now == CNT_W'(lef_pkg::CYCLES_PER_SECOND - 1);
		counted = cycle_time;
		counted[lef_pkg::OFF_LSB +: OFF_W] = off_wrap
			? OFF_W'(off_sum - (OFF_W+1)'(lef_pkg::OFFSET_WRAP))
			: off_sum[OFF_W-1:0];
		if (off_wrap) begin
			counted[lef_pkg::CNT_LSB +: CNT_W] = cnt_wrap
				? CNT_W'(0) : cnt_now + CNT_W'(1);
		end
		if (cnt_wrap) begin
			counted[lef_pkg::SEC_LSB +: SEC_W] = sec_now + SEC_W'(1);
		end
		// Software write overrides the count in the written byte lanes
		ct_wr = wr_go && wr_a8 == lef_pkg::ADDR_CYCLE_TIME;
		next_cycle_time = ct_wr
			? (counted & ~wr_mask) | (wr_data & wr_mask) : counted;
	end

	// Event flags, mask and header strip control
	always_comb begin
		next_tx_idle_q = tx_idle;
		next_cs_seen = cs_seen || ev_cycle_start;
		next_wrap_seen = wrap_seen;
		flag_set = 32'h0;
		flag_set[lef_pkg::BIT_CYCLE_SECOND_FLAG] = cnt_wrap;
		flag_set[lef_pkg::BIT_HDR_READ] = ev_rx_header_read
			&& !rx_header_strip_ctrl;
		flag_set[lef_pkg::BIT_FAIR_GAP] = ev_fair_gap;
		flag_set[lef_pkg::BIT_TX_IDLE] = tx_idle && !tx_idle_q;
		flag_set[lef_pkg::BIT_CY_DONE] = ev_arb_gap && cs_seen;
		if (ev_arb_gap && cs_seen) begin
			next_cs_seen = ev_cycle_start;
		end
		flag_set[lef_pkg::BIT_CY_PEND] = off_wrap || (ct_wr
			&& next_cycle_time[lef_pkg::OFF_LSB +: OFF_W] == OFF_W'(0));
		// A received cycle start in the wrap cycle counts as in between
		if (ev_cycle_start_rx) begin
			next_wrap_seen = off_wrap;
		end else if (off_wrap) begin
			next_wrap_seen = 1'b1;
			flag_set[lef_pkg::BIT_CY_LOST] = wrap_seen;
		end
		flag_set[lef_pkg::BIT_CY_ARBF] = ev_cycle_arb_lost;
		flag_set[lef_pkg::BIT_ATX_END] = ev_async_tx_complete
			|| ev_async_rx_response;
		flag_set[lef_pkg::BIT_ARX_REQ] = ev_async_rx_request;
		flag_set[lef_pkg::BIT_MGMT_DONE] = ev_mgmt_orb_stored;
		flag_set[lef_pkg::BIT_CMD_DONE] = ev_cmd_orb_stored;
		flag_set[lef_pkg::BIT_DTX_DONE] = ev_dma_tx_all_done;
		flag_set[lef_pkg::BIT_DRX_DONE] = ev_dma_rx_all_done;
		flag_set[lef_pkg::BIT_TX_EXPR] = ev_tx_failed;
		flag_set[lef_pkg::BIT_AGENT_WR] = ev_agent_write;
		flag_clr = 32'h0;
		if (wr_go && wr_a8 == lef_pkg::ADDR_EVENT_FLAGS) begin
			flag_clr = wr_data & wr_mask & FLAGS_IMPL;
		end
		flag_clr[lef_pkg::BIT_CY_PEND] = flag_clr[lef_pkg::BIT_CY_PEND]
			|| ev_iso_cycle_end;
		// Set wins over clear so no event is lost
		next_flags = (flags & ~flag_clr) | flag_set;
		next_flag_mask = flag_mask;
		if (wr_go && wr_a8 == lef_pkg::ADDR_FLAG_MASK) begin
			next_flag_mask = (flag_mask & ~wr_mask)
				| (wr_data & wr_mask & FLAGS_IMPL);
		end
		next_strip = rx_header_strip_ctrl;
		if (wr_go && wr_a8 == lef_pkg::ADDR_HDR_CTRL
			&& wr_strb[lef_pkg::BIT_HDR_STRIP / 8]) begin
			next_strip = wr_data[lef_pkg::BIT_HDR_STRIP];
		end
		next_irq_n = !(|(next_flags & next_flag_mask));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= lef_pkg::RESP_OKAY;
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= lef_pkg::RESP_OKAY;
			wr_addr <= '0;
			wr_data <= 32'h0;
			wr_strb <= 4'h0;
			cycle_time <= lef_pkg::CYCLE_TIME_RESET;
			flags <= lef_pkg::FLAGS_RESET;
			flag_mask <= lef_pkg::MASK_RESET;
			rx_header_strip_ctrl <= lef_pkg::HDR_STRIP_RESET;
			tick_acc <= 6'h0;
			wrap_seen <= 1'b0;
			cs_seen <= 1'b0;
			tx_idle_q <= 1'b0;
			irq_out_n <= 1'b1;
		end else begin
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
			wr_strb <= next_wr_strb;
			cycle_time <= next_cycle_time;
			flags <= next_flags;
			flag_mask <= next_flag_mask;
			rx_header_strip_ctrl <= next_strip;
			tick_acc <= next_tick_acc;
			wrap_seen <= next_wrap_seen;
			cs_seen <= next_cs_seen;
			tx_idle_q <= next_tx_idle_q;
			irq_out_n <= next_irq_n;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_offset_range: assert property (
		off_wrap && !ct_wr |=> cycle_time[OFF_W-1:0] < 12'h002)
		else $error("offset did not wrap to zero");
	a_second_flag: assert property (
		cnt_wrap |=> flags[lef_pkg::BIT_CYCLE_SECOND_FLAG])
		else $error("seconds step did not set flag");
	a_pend_hold: assert property (
		off_wrap ##1 (!ev_iso_cycle_end && !wr_go)[*2] |->
			flags[lef_pkg::BIT_CY_PEND])
		else $error("pending flag dropped early");
	a_lost_rise: assert property (
		$rose(flags[lef_pkg::BIT_CY_LOST]) |->
			$past(off_wrap) && !$past(ev_cycle_start_rx))
		else $error("cycle lost set without rollover");
	a_arx_only_req: assert property (
		$rose(flags[lef_pkg::BIT_ARX_REQ]) |-> $past(ev_async_rx_request))
		else $error("receive flag set without a request");
	a_atx_end: assert property (
		ev_async_rx_response |=> flags[lef_pkg::BIT_ATX_END])
		else $error("response did not set transmit end");
	a_hdr_gate: assert property (
		$rose(flags[lef_pkg::BIT_HDR_READ]) |->
			$past(ev_rx_header_read) && !$past(rx_header_strip_ctrl))
		else $error("header flag set while stripping");
	a_cy_done_gate: assert property (
		$rose(flags[lef_pkg::BIT_CY_DONE]) |->
			$past(ev_arb_gap) && $past(cs_seen))
		else $error("cycle done set without a prior start");
	a_irq_pin: assert property (
		irq_out_n == !(|(flags & flag_mask)))
		else $error("interrupt pin disagrees with flags");
	a_flag_sticky: assert property (
		flags[lef_pkg::BIT_DTX_DONE] && !wr_go |=>
			flags[lef_pkg::BIT_DTX_DONE])
		else $error("flag cleared without a write");
	a_write_answer: assert property (
		wr_go |=> bvalid ##0 $past(awready) == 1'b0)
		else $error("write not answered");

	c_cycle_lost: cover property (flag_set[lef_pkg::BIT_CY_LOST]);
	c_second_step: cover property (cnt_wrap);
	c_set_and_clear: cover property (
		flag_set[lef_pkg::BIT_AGENT_WR] && flag_clr[lef_pkg::BIT_AGENT_WR]);
	c_irq_asserted: cover property ($fell(irq_out_n));
endmodule
`default_nettype wire

// ==== sim/lef_host_model.sv ====
// Host processor model: AXI4-Lite master for register access
`timescale 1ns/1ps
`default_nettype none
module lef_host_model (
	input wire logic aclk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// Address and data go up together; each drops only when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] r);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (!ta && awready) begin
				ta = 1'b1;
				awvalid <= 1'b0;
			end
			if (!tw && wready) begin
				tw = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== sim/lef_event_flags_cycle_timer_tb.sv ====
// Self-checking bench for the event flags and cycle timer block
`timescale 1ns/1ps
`default_nettype none
module lef_event_flags_cycle_timer_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [16:0] ev = '0;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d, d2;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, strip, irq_out_n;
	int n_mismatch = 0;
	int checks = 0;
	localparam logic [7:0] FL = lef_pkg::ADDR_EVENT_FLAGS;
	localparam logic [7:0] CT = lef_pkg::ADDR_CYCLE_TIME;
	always #25 aclk = ~aclk;
	lef_host_model u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	lef_event_flags_cycle_timer u_dut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .ev_rx_header_read(ev[0]),
		.ev_fair_gap(ev[1]), .tx_idle(ev[2]), .ev_arb_gap(ev[3]),
		.ev_cycle_start(ev[4]), .ev_cycle_start_rx(ev[5]),
		.ev_iso_cycle_end(ev[6]), .ev_cycle_arb_lost(ev[7]),
		.ev_async_tx_complete(ev[8]), .ev_async_rx_response(ev[9]),
		.ev_async_rx_request(ev[10]), .ev_mgmt_orb_stored(ev[11]),
		.ev_cmd_orb_stored(ev[12]), .ev_dma_tx_all_done(ev[13]),
		.ev_dma_rx_all_done(ev[14]), .ev_tx_failed(ev[15]),
		.ev_agent_write(ev[16]), .rx_header_strip_ctrl(strip),
		.irq_out_n(irq_out_n));
	task automatic chk(input string nm, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		u_host.wr(a, v, r);
		chk("bresp", r, lef_pkg::RESP_OKAY);
	endtask
	task automatic rd(input logic [7:0] a);
		u_host.rd(a, d, r);
	endtask
	task automatic pulse(input int i);
		@(posedge aclk);
		ev[i] <= 1'b1;
		@(posedge aclk);
		ev[i] <= 1'b0;
	endtask
	// Event i must set bit b, leave bit n clear, then clear on write-one
	task automatic ev_case(input int i, input int b, input int n);
		pulse(i);
		rd(FL);
		chk("flag_set", d[b], 1'b1);
		chk("flag_other", d[n], 1'b0);
		wr(FL, 32'h1 << b);
		rd(FL);
		chk("flag_clr", d[b], 1'b0);
	endtask
	task automatic t_reset();
		chk("irq_rst", irq_out_n, 1'b1);
		rd(FL);
		chk("flags_rst", d, lef_pkg::FLAGS_RESET);
		rd(CT);
		chk("ct_rst", d[31:12], 20'h0);
		d2 = d;
		// Samples land 400 edges apart, whole tick patterns, so exact
		repeat (397) @(posedge aclk);
		rd(CT);
		chk("ct_rate", d[11:0] - d2[11:0], 12'd500);
	endtask
	task automatic t_flags();
		pulse(3);
		rd(FL);
		chk("gap_alone", d[lef_pkg::BIT_CY_DONE], 1'b0);
		pulse(4);
		ev_case(3, lef_pkg::BIT_CY_DONE, 16);
		ev_case(0, lef_pkg::BIT_HDR_READ, 16);
		ev_case(1, lef_pkg::BIT_FAIR_GAP, 16);
		ev_case(2, lef_pkg::BIT_TX_IDLE, 16);
		ev_case(7, lef_pkg::BIT_CY_ARBF, 16);
		ev_case(8, lef_pkg::BIT_ATX_END, lef_pkg::BIT_ARX_REQ);
		ev_case(9, lef_pkg::BIT_ATX_END, lef_pkg::BIT_ARX_REQ);
		ev_case(10, lef_pkg::BIT_ARX_REQ, lef_pkg::BIT_ATX_END);
		ev_case(11, lef_pkg::BIT_MGMT_DONE, 16);
		ev_case(12, lef_pkg::BIT_CMD_DONE, 16);
		ev_case(13, lef_pkg::BIT_DTX_DONE, 16);
		ev_case(14, lef_pkg::BIT_DRX_DONE, 16);
		ev_case(15, lef_pkg::BIT_TX_EXPR, 16);
		ev_case(16, lef_pkg::BIT_AGENT_WR, 16);
		wr(lef_pkg::ADDR_HDR_CTRL, 32'h8000_0000);
		chk("strip", strip, 1'b1);
		pulse(0);
		rd(FL);
		chk("hdr_strip", d[lef_pkg::BIT_HDR_READ], 1'b0);
		wr(lef_pkg::ADDR_HDR_CTRL, 32'h0);
		u_host.wr(8'h20, 32'hffff_ffff, r);
		chk("un_bresp", r, lef_pkg::RESP_SLVERR);
		u_host.rd(8'h20, d, r);
		chk("un_rresp", r, lef_pkg::RESP_SLVERR);
		chk("un_rdata", d, 32'h0);
	endtask
	task automatic t_irq();
		wr(lef_pkg::ADDR_FLAG_MASK, 32'h1 << lef_pkg::BIT_AGENT_WR);
		chk("irq_idle", irq_out_n, 1'b1);
		pulse(16);
		@(posedge aclk);
		chk("irq_low", irq_out_n, 1'b0);
		rd(FL);
		chk("summary", d[lef_pkg::BIT_SUMMARY], 1'b1);
		wr(FL, 32'h1 << lef_pkg::BIT_AGENT_WR);
		@(posedge aclk);
		chk("irq_clr", irq_out_n, 1'b1);
		wr(lef_pkg::ADDR_FLAG_MASK, 32'h0);
	endtask
	task automatic t_timer();
		wr(FL, 32'hffff_ffff);
		wr(CT, {7'h05, 13'h1f3f, 12'hc30});
		repeat (20) @(posedge aclk);
		rd(CT);
		chk("sec", d[31:25], 7'h06);
		chk("cnt", d[24:12], 13'h0);
		rd(FL);
		chk("cycle_second_flag", d[lef_pkg::BIT_CYCLE_SECOND_FLAG], 1'b1);
		chk("pend", d[lef_pkg::BIT_CY_PEND], 1'b1);
		pulse(6);
		rd(FL);
		chk("pend_end", d[lef_pkg::BIT_CY_PEND], 1'b0);
		pulse(5);
		wr(FL, 32'hffff_ffff);
		// One received start between wraps keeps the lost flag quiet
		repeat (2500) @(posedge aclk);
		rd(FL);
		chk("lost_no", d[lef_pkg::BIT_CY_LOST], 1'b0);
		repeat (2500) @(posedge aclk);
		rd(FL);
		chk("lost", d[lef_pkg::BIT_CY_LOST], 1'b1);
	endtask
	task automatic print_verdict();
		if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_flags();
		t_irq();
		t_timer();
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		print_verdict();
	end
endmodule
`default_nettype wire
